// [rtl/ppm_port.sv]
// parallel port: master strobes and slave buffers behind an avalon-mm register slave
// assumes a 10 mhz clock; host pins in slave mode are asynchronous and synchronised here
//
// Overview of operation
// RQ1 - busy flag reads 1 during a master transfer, 0 when idle
// RQ2 - interrupt select: 00 none, 01 per cycle, 11 buffer 3 or address 3
// RQ3 - address step: 01 increment, 10 decrement, 00 hold, 11 legacy buffer step
// RQ4 - wide bit gives two byte transfers per data access, else one
// RQ5 - mode select: master 1, master 2, enhanced slave, legacy slave
// RQ6 - setup and address phase last field plus one periods
// RQ7 - strobe lasts one period plus strobe field extra periods
// RQ8 - hold after strobe lasts field plus one periods
// RQ9 - strobe field zero makes setup and hold fields ignored
// RQ10 - target bit 15 is chip select two for select functions 10, 01
// RQ11 - target bit 14 is chip select one only for select function 10
// RQ12 - target low 14 bits are address; second output buffer in enhanced slave
// RQ13 - pin enable bits hand address pins to the port, else general io
// RQ14 - input full flag is 1 only when all input buffers hold data
// RQ15 - host write to full input buffer sets overrun; software clears it
// RQ16 - per-buffer input flags set on host write, cleared on internal read
// RQ17 - output empty flag is 1 only when all output buffers empty
// RQ18 - host read of empty output buffer sets underrun; software clears it
// RQ19 - per-buffer output flags set until internal write; reset to 1
// RQ20 - port enable 0 blocks every external access
// RQ21 - address sharing: 00 separate, 01 low byte muxed, 10 all muxed; the code gives 01, 10 and 11 the same address phase
// RQ22 - select function: 10 both selects, 01 select two only, 00 none
// RQ23 - polarity bits make each strobe and select active high when 1
// RQ24 - data access starts a master transfer; step applies after the cycle
`timescale 1ns/1ns
`include "ppm_defs.svh"
module ppm_port #(
    parameter int TP_CYCLES = `PPM_TP_CYC
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [5:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    output logic PORT_EVENT,
    input wire logic [7:0] BYTE_LINES_I,
    output logic [7:0] BYTE_LINES_O,
    output logic BYTE_LINES_OE_N,
    input wire logic [1:0] LOCATION_LINES_I,
    output logic [15:0] LOCATION_LINES_O,
    output logic [15:0] LOCATION_LINES_OE_N,
    output logic READ_STROBE_PIN,
    output logic WRITE_STROBE_PIN,
    input wire logic HOST_READ_I,
    input wire logic HOST_WRITE_I,
    output logic ENABLE_STROBE_PIN,
    output logic BYTE_ENABLE_PIN,
    output logic CHIP_SELECT_ONE,
    output logic CHIP_SELECT_TWO,
    output logic LOW_LATCH_STROBE,
    output logic HIGH_LATCH_STROBE
);
    ppm_pkg::ppm_state_t s_r;
    ppm_pkg::ppm_state_t s_nxt;
    ////////////////////////////////////////////////////////////////////////////////
    logic en;
    logic master;
    logic wide;
    logic [1:0] pmode;
    logic [1:0] interrupt_trigger_select;
    logic [1:0] address_step_select;
    logic [1:0] setup_delay_select;
    logic [3:0] strobe_delay_select;
    logic [1:0] hold_delay_select;
    logic [1:0] amux;
    logic [1:0] select_pin_function;
    logic req;
    logic [5:0] adr;
    logic tick;
    logic [3:0] tp_cnt_r;
    logic [15:0] status;
    logic [15:0] next_addr;
    logic [1:0] hidx;
    logic h_wr_ev;
    logic h_rd_ev;
    assign en = s_r.control[`PPM_BIT_ENABLE];
    assign select_pin_function = s_r.control[7:6];
    assign amux = s_r.control[12:11];
    assign interrupt_trigger_select = s_r.mode[13:12];
    assign address_step_select = s_r.mode[11:10];
    assign wide = s_r.mode[`PPM_BIT_WIDE - 1];
    assign pmode = s_r.mode[8:7];
    assign setup_delay_select = s_r.mode[6:5];
    assign strobe_delay_select = s_r.mode[4:1];
    assign hold_delay_select = {s_r.mode[0], s_r.padcfg[1]};
    assign master = pmode[1]; // RQ5
    assign req = (AVS_READ | AVS_WRITE) & s_r.wait_r;
    assign adr = AVS_ADDRESS;
    assign h_wr_ev = s_r.h_wr_s[1] & ~s_r.h_wr_d;
    assign h_rd_ev = s_r.h_rd_s[1] & ~s_r.h_rd_d;
    assign hidx = (pmode == 2'h1) ? s_r.h_a_s2 : s_r.leg_ptr;
    assign status = {&s_r.in_full, s_r.in_ovr, 2'h0, s_r.in_full,
                     &s_r.out_empty, s_r.out_unr, 2'h0, s_r.out_empty}; // RQ14 RQ17
    ////////////////////////////////////////////////////////////////////////////////
    // peripheral clock period divider; one tick per period
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            tp_cnt_r <= 4'h0;
        else if (tick)
            tp_cnt_r <= 4'h0;
        else
            tp_cnt_r <= tp_cnt_r + 4'h1;
    end
    assign tick = (tp_cnt_r == 4'(TP_CYCLES - 1));
    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.irq = 1'b0;
        s_nxt.wait_r = 1'b1;
        s_nxt.h_wr_s = {s_r.h_wr_s[0], HOST_WRITE_I};
        s_nxt.h_rd_s = {s_r.h_rd_s[0], HOST_READ_I};
        s_nxt.h_wr_d = s_r.h_wr_s[1];
        s_nxt.h_rd_d = s_r.h_rd_s[1];
        s_nxt.h_d_s1 = BYTE_LINES_I;
        s_nxt.h_d_s2 = s_r.h_d_s1;
        s_nxt.h_a_s1 = LOCATION_LINES_I;
        s_nxt.h_a_s2 = s_r.h_a_s1;
        next_addr = s_r.target;
        // bus slave: one wait cycle, answer on second edge
        if ((AVS_READ | AVS_WRITE) & ~s_r.wait_r)
            s_nxt.wait_r = 1'b1;
        if (req)
        begin
            s_nxt.wait_r = 1'b0;
            s_nxt.rdata = 32'h0;
            case (adr)
                `PPM_OFS_CONTROL: s_nxt.rdata = {16'h0, s_r.control};
                `PPM_OFS_MODE: s_nxt.rdata = {16'h0, s_r.phase != ppm_pkg::PH_IDLE, s_r.mode,
                    s_r.padcfg[1]}; // RQ1
                `PPM_OFS_TARGET: s_nxt.rdata = {16'h0, s_r.target};
                `PPM_OFS_PINEN: s_nxt.rdata = {16'h0, s_r.pinen};
                `PPM_OFS_STATUS: s_nxt.rdata = {16'h0, status};
                `PPM_OFS_DATA: s_nxt.rdata = {16'h0, s_r.data_hi, s_r.data_lo};
                `PPM_OFS_PADCFG: s_nxt.rdata = {31'h0, s_r.padcfg[0]};
                `PPM_OFS_INBUF: s_nxt.rdata = s_r.in_buf;
                `PPM_OFS_OUTBUF: s_nxt.rdata = s_r.out_buf;
                default: s_nxt.rdata = 32'h0;
            endcase
            if (AVS_WRITE & AVS_BYTEENABLE[0] & AVS_BYTEENABLE[1])
            begin
                case (adr)
                    `PPM_OFS_CONTROL: s_nxt.control = AVS_WRITEDATA[15:0] & 16'hBFFF;
                    `PPM_OFS_MODE:
                    begin
                        s_nxt.mode = {AVS_WRITEDATA[14:2], AVS_WRITEDATA[1]};
                        s_nxt.padcfg[1] = AVS_WRITEDATA[0];
                    end
                    `PPM_OFS_TARGET: s_nxt.target = AVS_WRITEDATA[15:0];
                    `PPM_OFS_PINEN: s_nxt.pinen = AVS_WRITEDATA[15:0];
                    `PPM_OFS_STATUS:
                    begin
                        s_nxt.in_ovr = s_r.in_ovr & AVS_WRITEDATA[`PPM_BIT_OVR]; // RQ15
                        s_nxt.out_unr = s_r.out_unr & AVS_WRITEDATA[`PPM_BIT_UNR]; // RQ18
                    end
                    `PPM_OFS_PADCFG: s_nxt.padcfg[0] = AVS_WRITEDATA[0];
                    `PPM_OFS_OUTBUF:
                    begin
                        s_nxt.out_buf = AVS_WRITEDATA;
                        s_nxt.out_empty = 4'h0; // RQ19
                        if (pmode == 2'h1)
                            s_nxt.target = AVS_WRITEDATA[31:16]; // RQ12
                    end
                    default: ;
                endcase
            end
            if (AVS_READ & (adr == `PPM_OFS_INBUF))
                s_nxt.in_full = 4'h0; // RQ16
            // master transfer start on data access
            if ((adr == `PPM_OFS_DATA) & master & en & (s_r.phase == ppm_pkg::PH_IDLE)) // RQ20 RQ24
            begin
                if (AVS_WRITE)
                begin
                    s_nxt.data_lo = AVS_WRITEDATA[7:0];
                    s_nxt.data_hi = AVS_WRITEDATA[15:8];
                end
                s_nxt.is_read = AVS_READ;
                s_nxt.second = 1'b0;
                s_nxt.cnt = 4'h0;
                s_nxt.phase = (amux != 2'h0) ? ppm_pkg::PH_ADDR : ppm_pkg::PH_SETUP; // RQ21
            end
        end
        // master phase engine, counts in peripheral clock periods
        if (tick)
        begin
            s_nxt.cnt = s_r.cnt + 4'h1;
            case (s_r.phase)
                ppm_pkg::PH_ADDR:
                    if (strobe_delay_select == 4'h0 || s_r.cnt == {2'h0, setup_delay_select}) // RQ6 RQ9
                    begin
                        s_nxt.cnt = 4'h0;
                        s_nxt.phase = ppm_pkg::PH_SETUP;
                    end
                ppm_pkg::PH_SETUP:
                    if (strobe_delay_select == 4'h0 || s_r.cnt == {2'h0, setup_delay_select}) // RQ6 RQ9
                    begin
                        s_nxt.cnt = 4'h0;
                        s_nxt.phase = ppm_pkg::PH_STROBE;
                    end
                ppm_pkg::PH_STROBE:
                    if (s_r.cnt == strobe_delay_select) // RQ7
                    begin
                        s_nxt.cnt = 4'h0;
                        s_nxt.phase = ppm_pkg::PH_HOLD;
                        if (s_r.is_read)
                        begin
                            if (s_r.second)
                                s_nxt.data_hi = s_r.h_d_s2;
                            else
                                s_nxt.data_lo = s_r.h_d_s2;
                        end
                    end
                ppm_pkg::PH_HOLD:
                    if (strobe_delay_select == 4'h0 || s_r.cnt == {2'h0, hold_delay_select}) // RQ8 RQ9
                    begin
                        s_nxt.cnt = 4'h0;
                        if (interrupt_trigger_select == 2'h1)
                            s_nxt.irq = 1'b1; // RQ2
                        if (address_step_select == 2'h1)
                            next_addr = {s_r.target[15:14], s_r.target[13:0] + 14'h1}; // RQ3
                        else if (address_step_select == 2'h2)
                            next_addr = {s_r.target[15:14], s_r.target[13:0] - 14'h1}; // RQ3
                        s_nxt.target = next_addr;
                        if (wide & ~s_r.second) // RQ4
                        begin
                            s_nxt.second = 1'b1;
                            s_nxt.phase = (amux != 2'h0) ? ppm_pkg::PH_ADDR : ppm_pkg::PH_SETUP;
                        end
                        else
                            s_nxt.phase = ppm_pkg::PH_IDLE; // RQ24
                    end
                default: s_nxt.cnt = 4'h0;
            endcase
        end
        // slave side: host strobes after two-flop synchronisers
        if (~master & en)
        begin
            if (h_wr_ev)
            begin
                if (s_r.in_full[hidx])
                    s_nxt.in_ovr = 1'b1; // RQ15
                s_nxt.in_full[hidx] = 1'b1; // RQ16
                s_nxt.in_buf[hidx*8 +: 8] = s_r.h_d_s2;
            end
            if (h_rd_ev)
            begin
                if (s_r.out_empty[hidx])
                    s_nxt.out_unr = 1'b1; // RQ18
                s_nxt.out_empty[hidx] = 1'b1;
            end
            if ((h_wr_ev | h_rd_ev) & (hidx == 2'h3) & (interrupt_trigger_select == 2'h3))
                s_nxt.irq = 1'b1; // RQ2
            if ((h_wr_ev | h_rd_ev) & (pmode == 2'h0) & (address_step_select == 2'h3))
                s_nxt.leg_ptr = s_r.leg_ptr + 2'h1; // RQ3
        end
        // pin drive; polarity applied, output enable active low
        s_nxt.pin_d_o = (s_r.phase == ppm_pkg::PH_ADDR) ? (s_r.second ? s_r.target[15:8] : s_r.target[7:0])
            : (master ? (s_r.second ? s_r.data_hi : s_r.data_lo) : s_r.out_buf[hidx*8 +: 8]);
        s_nxt.pin_d_oe_n = ~(en & ((master & ((s_r.phase == ppm_pkg::PH_ADDR) | ~s_r.is_read)
            & (s_r.phase != ppm_pkg::PH_IDLE)) | (~master & s_r.h_rd_s[1]))); // RQ20
        s_nxt.pin_a = {s_r.target[15:14], s_r.target[13:0]}; // RQ12
        s_nxt.pin_a_oe_n = ~(s_r.pinen & {16{en & master}}); // RQ13
        s_nxt.rd_o = s_r.control[0] ^ ~(en & (s_r.phase == ppm_pkg::PH_STROBE)
            & (pmode == 2'h3 ? s_r.is_read : (pmode == 2'h2) & s_r.is_read)); // RQ5 RQ23
        s_nxt.wr_o = s_r.control[1] ^ ~(en & (s_r.phase == ppm_pkg::PH_STROBE) & (pmode == 2'h2)
            & ~s_r.is_read); // RQ23
        s_nxt.en_o = s_r.control[1] ^ ~(en & (s_r.phase == ppm_pkg::PH_STROBE) & (pmode == 2'h3)); // RQ5
        s_nxt.be_o = s_r.control[2] ^ ~(en & wide & (s_r.phase != ppm_pkg::PH_IDLE)); // RQ23
        s_nxt.cs2_o = (select_pin_function == 2'h2 || select_pin_function == 2'h1) ? s_r.control[4] ^ ~(s_r.target[15] & en) : s_r.target[15]; // RQ10 RQ22
        s_nxt.cs1_o = (select_pin_function == 2'h2) ? s_r.control[3] ^ ~(s_r.target[14] & en) : s_r.target[14]; // RQ11 RQ22
        s_nxt.all_o = s_r.control[5] ^ ~(en & (s_r.phase == ppm_pkg::PH_ADDR) & ~s_r.second); // RQ23
        s_nxt.alh_o = s_r.control[5] ^ ~(en & (s_r.phase == ppm_pkg::PH_ADDR) & s_r.second);
    end
    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            s_r <= '0;
            s_r.out_empty <= 4'hF; // RQ19
            s_r.pin_d_oe_n <= 1'b1;
            s_r.pin_a_oe_n <= 16'hFFFF;
            s_r.rd_o <= 1'b1;
            s_r.wr_o <= 1'b1;
            s_r.en_o <= 1'b1;
            s_r.be_o <= 1'b1;
            s_r.all_o <= 1'b1;
            s_r.alh_o <= 1'b1;
        end
        else
            s_r <= s_nxt;
    end
    assign AVS_READDATA = s_r.rdata;
    assign AVS_WAITREQUEST = s_r.wait_r;
    assign PORT_EVENT = s_r.irq;
    assign BYTE_LINES_O = s_r.pin_d_o;
    assign BYTE_LINES_OE_N = s_r.pin_d_oe_n;
    assign LOCATION_LINES_O = s_r.pin_a;
    assign LOCATION_LINES_OE_N = s_r.pin_a_oe_n;
    assign READ_STROBE_PIN = s_r.rd_o;
    assign WRITE_STROBE_PIN = s_r.wr_o;
    assign ENABLE_STROBE_PIN = s_r.en_o;
    assign BYTE_ENABLE_PIN = s_r.be_o;
    assign CHIP_SELECT_ONE = s_r.cs1_o;
    assign CHIP_SELECT_TWO = s_r.cs2_o;
    assign LOW_LATCH_STROBE = s_r.all_o;
    assign HIGH_LATCH_STROBE = s_r.alh_o;
    ////////////////////////////////////////////////////////////////////////////////
    a_busy_on_start: assert property (@(posedge CLK) disable iff (!RST_N)
        req & (adr == `PPM_OFS_DATA) & master & en & (s_r.phase == ppm_pkg::PH_IDLE)
        |=> s_r.phase != ppm_pkg::PH_IDLE) else $error("transfer did not start"); // RQ24
    a_no_access_off: assert property (@(posedge CLK) disable iff (!RST_N)
        !en |=> s_r.pin_d_oe_n) else $error("data driven while disabled"); // RQ20
    a_empty_reset: assert property (@(posedge CLK) disable iff (!RST_N)
        req & AVS_WRITE & (adr == `PPM_OFS_OUTBUF) & (&AVS_BYTEENABLE[1:0]) |=> s_r.out_empty == 4'h0)
        else $error("output flags not cleared"); // RQ19
    a_ovr_sticky: assert property (@(posedge CLK) disable iff (!RST_N)
        s_r.in_ovr & !(req & AVS_WRITE & (adr == `PPM_OFS_STATUS)) |=> s_r.in_ovr)
        else $error("overrun lost"); // RQ15
    a_unr_sticky: assert property (@(posedge CLK) disable iff (!RST_N)
        s_r.out_unr & !(req & AVS_WRITE & (adr == `PPM_OFS_STATUS)) |=> s_r.out_unr)
        else $error("underrun lost"); // RQ18
    a_in_clear_read: assert property (@(posedge CLK) disable iff (!RST_N)
        req & AVS_READ & (adr == `PPM_OFS_INBUF) & !(~master & en & h_wr_ev) |=> s_r.in_full == 4'h0)
        else $error("input flags not cleared"); // RQ16
    a_cs1_function: assert property (@(posedge CLK) disable iff (!RST_N)
        select_pin_function == 2'h0 |=> CHIP_SELECT_ONE == $past(s_r.target[14])) else $error("cs1 not address"); // RQ11
    a_strobe_len: assert property (@(posedge CLK) disable iff (!RST_N)
        $rose(s_r.phase == ppm_pkg::PH_STROBE) & (strobe_delay_select == 4'h0) & tick & (TP_CYCLES == 1)
        |=> s_r.phase != ppm_pkg::PH_STROBE) else $error("strobe too long"); // RQ7
    c_master_write: cover property (@(posedge CLK) disable iff (!RST_N)
        s_r.phase == ppm_pkg::PH_HOLD & !s_r.is_read);
    c_wide_pair: cover property (@(posedge CLK) disable iff (!RST_N) s_r.second & s_r.phase == ppm_pkg::PH_STROBE);
    c_host_write: cover property (@(posedge CLK) disable iff (!RST_N) ~master & en & h_wr_ev);
    c_overrun: cover property (@(posedge CLK) disable iff (!RST_N) $rose(s_r.in_ovr));
endmodule

// [rtl/ppm_defs.svh]
// register offsets, field positions, reset values and timing counts of the parallel port block
// assumes a 32-bit avalon-mm word bus, byte addressing, one register per word
`ifndef PPM_DEFS_SVH
`define PPM_DEFS_SVH
`define PPM_OFS_CONTROL 6'h00
`define PPM_OFS_MODE 6'h04
`define PPM_OFS_TARGET 6'h08
`define PPM_OFS_PINEN 6'h0C
`define PPM_OFS_STATUS 6'h10
`define PPM_OFS_DATA 6'h14
`define PPM_OFS_PADCFG 6'h18
`define PPM_OFS_INBUF 6'h1C
`define PPM_OFS_OUTBUF 6'h20
`define PPM_BIT_ENABLE 15
`define PPM_BIT_BUSY 15
`define PPM_BIT_WIDE 10
`define PPM_BIT_OVR 14
`define PPM_BIT_UNR 6
`define PPM_RST_STATUS 16'h008F
`define PPM_PERIOD_NS 100
`define PPM_CLK_NS 100
`define PPM_TP_CYC ((`PPM_PERIOD_NS + `PPM_CLK_NS - 1) / `PPM_CLK_NS)
`endif

// [rtl/ppm_pkg.sv]
// types of the parallel port block
// no assumptions beyond a sv-2012 compiler
package ppm_pkg;
    typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_SETUP, PH_STROBE, PH_HOLD} ppm_phase_t;
    typedef struct packed {
        logic [15:0] control;
        logic [13:0] mode;
        logic [15:0] target;
        logic [15:0] pinen;
        logic [1:0] padcfg;
        logic [7:0] data_lo;
        logic [7:0] data_hi;
        logic in_ovr;
        logic out_unr;
        logic [3:0] in_full;
        logic [3:0] out_empty;
        logic [31:0] in_buf;
        logic [31:0] out_buf;
        ppm_phase_t phase;
        logic [3:0] cnt;
        logic second;
        logic is_read;
        logic wait_r;
        logic [31:0] rdata;
        logic irq;
        logic [7:0] pin_d_o;
        logic pin_d_oe_n;
        logic [15:0] pin_a;
        logic [15:0] pin_a_oe_n;
        logic rd_o;
        logic wr_o;
        logic en_o;
        logic be_o;
        logic cs1_o;
        logic cs2_o;
        logic all_o;
        logic alh_o;
        logic [1:0] h_wr_s;
        logic [1:0] h_rd_s;
        logic h_wr_d;
        logic h_rd_d;
        logic [7:0] h_d_s1;
        logic [7:0] h_d_s2;
        logic [1:0] h_a_s1;
        logic [1:0] h_a_s2;
        logic [1:0] leg_ptr;
    } ppm_state_t;
endpackage

// [tb/ppm_far_end.sv]
// far-side model: an external peripheral in master modes, an external host in slave modes
// assumes active-low read strobe (polarity bit 0) and host strobes requested by the bench
`timescale 1ns/1ns
module ppm_far_end #(
    parameter logic [7:0] PERIPH_BYTE = 8'hA5
) (
    input wire logic clk,
    input wire logic rd_strobe,
    input wire logic host_wr_go,
    input wire logic host_rd_go,
    input wire logic [7:0] host_byte,
    input wire logic [1:0] host_loc,
    output logic [7:0] byte_i,
    output logic [1:0] loc_i,
    output logic host_read,
    output logic host_write
);
    logic [7:0] last_byte = 8'h00;
    logic [1:0] last_loc = 2'h0;
    ////////////////////////////////////////////////////////////////
    // released lines toggle every cycle so a stale value never looks valid
    assign byte_i = host_wr_go ? host_byte : (rd_strobe === 1'b0 ? PERIPH_BYTE : ~last_byte);
    assign loc_i = (host_wr_go | host_rd_go) ? host_loc : ~last_loc;
    assign host_write = host_wr_go;
    assign host_read = host_rd_go;
    always @(posedge clk)
    begin
        last_byte <= byte_i;
        last_loc <= loc_i;
    end
endmodule

// [tb/tb_parallel_port_mode_status.sv]
// self-checking bench: avalon register accesses, master strobe timing, slave buffer flags
// assumes the register map of ppm_defs.svh and one clock at 10 mhz
`timescale 1ns/1ns
`include "ppm_defs.svh"
module tb_parallel_port_mode_status;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, port_event, byte_oe_n, rd_pin, wr_pin, host_rd, host_wr;
    logic [7:0] byte_i, byte_o;
    logic [1:0] loc_i;
    logic [15:0] loc_o, loc_oe_n;
    logic hw = 1'b0;
    logic hr = 1'b0;
    logic [7:0] hb = 8'h00;
    logic [1:0] hl = 2'h0;
    logic [8:0] wr_byte = 9'h000;
    int fail_count = 0;
    int checks = 0;
    int cyc = 0;
    int run = 0;
    int last_run = 0;
    int pulses = 0;
    int events = 0;
    int i, p0, e0;
    logic [31:0] rd;
    localparam logic [15:0] MW [3] = '{16'h2A4A, 16'h32C3, 16'h063C};
    localparam int EXP_P [3] = '{1, 1, 2};
    localparam int EXP_RUN [3] = '{3, 1, 16};
    localparam int EXP_EV [3] = '{1, 1, 0};
    localparam logic [15:0] EXP_TGT [3] = '{16'h0011, 16'h0010, 16'h0010};
    ppm_port dut (.CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
        .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(4'hF),
        .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .PORT_EVENT(port_event),
        .BYTE_LINES_I(byte_i), .BYTE_LINES_O(byte_o), .BYTE_LINES_OE_N(byte_oe_n),
        .LOCATION_LINES_I(loc_i), .LOCATION_LINES_O(loc_o), .LOCATION_LINES_OE_N(loc_oe_n),
        .READ_STROBE_PIN(rd_pin), .WRITE_STROBE_PIN(wr_pin), .HOST_READ_I(host_rd),
        .HOST_WRITE_I(host_wr), .ENABLE_STROBE_PIN(), .BYTE_ENABLE_PIN(), .CHIP_SELECT_ONE(),
        .CHIP_SELECT_TWO(), .LOW_LATCH_STROBE(), .HIGH_LATCH_STROBE());
    ppm_far_end far (.clk(clk), .rd_strobe(rd_pin), .host_wr_go(hw), .host_rd_go(hr), .host_byte(hb),
        .host_loc(hl), .byte_i(byte_i), .loc_i(loc_i), .host_read(host_rd), .host_write(host_wr));
    initial
    begin
        forever #50 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (port_event === 1'b1)
            events <= events + 1;
        if (wr_pin === 1'b0)
        begin
            run <= run + 1;
            wr_byte <= {byte_oe_n, byte_o};
        end
        else if (run != 0)
        begin
            last_run <= run;
            pulses <= pulses + 1;
            run <= 0;
        end
        if (cyc == 20000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // request held until the edge that samples waitrequest low
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] wd);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= w;
        avs_read <= ~w;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic chk_reg(input string nm, input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(nm, rd, exp);
    endtask
    // host strobes are asynchronous: held long enough for the two-flop synchroniser
    task automatic host(input logic w, input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        hb <= d;
        hl <= a;
        hw <= w;
        hr <= ~w;
        repeat (4) @(posedge clk);
        hw <= 1'b0;
        hr <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk_reg("status reset", `PPM_OFS_STATUS, 32'h008F);
        chk_reg("mode reset", `PPM_OFS_MODE, 32'h0000);
        chk_reg("unmapped", 6'h3C, 32'h0);
        bus(1'b1, `PPM_OFS_CONTROL, 32'h8700);
        bus(1'b1, `PPM_OFS_PINEN, 32'hC003);
        chk_reg("pin enables", `PPM_OFS_PINEN, 32'hC003);
        check("pin owners slave", loc_oe_n, 16'hFFFF);
        bus(1'b1, `PPM_OFS_TARGET, 32'h0010);
        for (i = 0; i < 3; i++)
        begin
            bus(1'b1, `PPM_OFS_MODE, MW[i]);
            p0 = pulses;
            e0 = events;
            bus(1'b1, `PPM_OFS_DATA, 32'hC35A);
            check("pin owners", loc_oe_n, 16'h3FFC);
            if (i == 2)
                chk_reg("busy set", `PPM_OFS_MODE, {16'h0, 1'b1, MW[i][14:0]});
            rd = 32'h8000;
            while (rd[15] !== 1'b0)
                bus(1'b0, `PPM_OFS_MODE, 32'h0);
            check("mode idle", rd, MW[i]);
            repeat (2) @(posedge clk);
            check("strobe count", pulses - p0, EXP_P[i]);
            check("strobe length", last_run, EXP_RUN[i]);
            check("strobe byte", wr_byte, (i == 2) ? 9'h0C3 : 9'h05A);
            check("events", events - e0, EXP_EV[i]);
            chk_reg("target step", `PPM_OFS_TARGET, EXP_TGT[i]);
        end
        bus(1'b0, `PPM_OFS_DATA, 32'h0);
        check("data written", rd, 32'hC35A);
        rd = 32'h8000;
        while (rd[15] !== 1'b0)
            bus(1'b0, `PPM_OFS_MODE, 32'h0);
        chk_reg("read bytes", `PPM_OFS_DATA, 32'hA5A5);
        bus(1'b1, `PPM_OFS_CONTROL, 32'h0000);
        p0 = pulses;
        bus(1'b1, `PPM_OFS_DATA, 32'h00A5);
        repeat (40) @(posedge clk);
        check("disabled strobes", pulses - p0, 0);
        bus(1'b1, `PPM_OFS_CONTROL, 32'h8700);
        bus(1'b1, `PPM_OFS_MODE, 32'h6100);
        e0 = events;
        for (i = 0; i < 4; i++)
            host(1'b1, i[1:0], 8'(8'h11 * (i + 1)));
        chk_reg("inputs full", `PPM_OFS_STATUS, 32'h8F8F);
        check("slot three event", events - e0, 1);
        host(1'b1, 2'h0, 8'h77);
        chk_reg("overrun", `PPM_OFS_STATUS, 32'hCF8F);
        chk_reg("input bytes", `PPM_OFS_INBUF, 32'h44332277);
        chk_reg("inputs read", `PPM_OFS_STATUS, 32'h408F);
        bus(1'b1, `PPM_OFS_STATUS, 32'h0000);
        chk_reg("overrun cleared", `PPM_OFS_STATUS, 32'h008F);
        host(1'b0, 2'h1, 8'h00);
        chk_reg("underrun", `PPM_OFS_STATUS, 32'h00CF);
        bus(1'b1, `PPM_OFS_OUTBUF, 32'hDDCCBBAA);
        chk_reg("outputs loaded", `PPM_OFS_STATUS, 32'h0040);
        tally_and_finish();
    end
endmodule
